//--- shared/pe_pkg.sv
// pe_pkg: register map, field layout and event carriers for the perf event block.
// assumes one core clock; all pipeline status arrives already in that domain.
package pe_pkg;
   // register byte offsets
   localparam logic [7:0] PE_CTRL_OFFSET   = 8'h00;
   localparam logic [7:0] PE_STATUS_OFFSET = 8'h04;
   localparam int         PE_ADDR_W        = 8;
   // field positions
   localparam int PE_CTRL_ENABLE_BIT   = 0;
   localparam int PE_STATUS_OWNER_BIT  = 0;
   localparam int PE_STATUS_ACTIVE_LSB = 1;
   // reset values
   localparam logic       PE_CTRL_ENABLE_RST = 1'b0;
   localparam logic       PE_PRIO_OWNER_RST  = 1'b0;
   // bus answers
   localparam logic [1:0] PE_RESP_OKAY   = 2'h0;
   localparam logic [1:0] PE_RESP_DECERR = 2'h3;
   // widths of the core
   localparam logic [2:0] PE_MAX_WIDTH = 3'h4;
   // software prefetch outcome codes
   localparam logic [1:0] PE_SWPF_TO_L2 = 2'h0;
   localparam logic [1:0] PE_SWPF_LOST  = 2'h1;
   localparam logic [1:0] PE_SWPF_HIT   = 2'h2;

   // per-thread status from issue, commit and cache logic
   typedef struct packed {
      logic       active;
      logic [2:0] issue_count;
      logic       sync_block;
      logic       window_block;
      logic       static_block;
      logic       phantom_branch;
      logic [2:0] commit_count;
      logic       head_valid;
      logic       head_ready;
      logic       head_mem;
      logic       head_store;
      logic       head_atomic;
      logic       head_data_ready;
      logic       head_noncache;
      logic       head_int_load;
      logic       head_l2_miss;
      logic       head_exec_busy;
      logic       head_fp;
      logic       head_branch_busy;
      logic       head_regwin_wait;
      logic       storeport_full;
      logic       gpr_port_limit;
      logic       fp_mixed;
      logic       itlb_miss;
      logic       dtlb_miss;
      logic       icache_miss;
      logic       dcache_miss;
      logic       fetch_miss_pending;
      logic       head_dmiss_pending;
      logic       swpf_valid;
      logic [1:0] swpf_result;
      logic       ithrash;
      logic       dthrash;
   } pe_thread_in_type;

   // per-thread one-cycle event qualifiers to the counters
   typedef struct packed {
      logic issue_zero_event, issue_one_event, issue_two_event;
      logic issue_three_event, issue_four_event;
      logic sync_issue_block, window_issue_block, decode_static_intlk, phantom_branch;
      logic data_wait_stall, noncache_data_stall, int_load_stall;
      logic l2_miss_data_stall, l2_miss_int_load_stall;
      logic empty_queue_stall, empty_queue_storeport_full;
      logic exec_completion_stall, branch_completion_stall, fp_completion_stall;
      logic regwin_wait_stall, commit_prio_wait;
      logic commit_zero_event, commit_one_event, commit_two_event, commit_three_event;
      logic write_port_limit_event;
      logic prio_data_wait_stall, prio_noncache_data_stall, prio_int_load_stall;
      logic prio_l2_miss_data_stall, prio_l2_miss_int_load_stall;
      logic prio_empty_queue_stall, prio_empty_queue_storeport_full;
      logic prio_exec_completion_stall, prio_branch_completion_stall;
      logic prio_fp_completion_stall;
      logic nonprio_regwin_wait, nonprio_commit_zero;
      logic fp_precision_mix, instr_micro_tlb_miss, data_micro_tlb_miss;
      logic icache_miss_event, dcache_miss_event;
      logic icache_miss_latency, dcache_miss_latency;
      logic swpf_to_l2, swpf_lost, swpf_l1_hit;
      logic icache_thrash_event, dcache_thrash_event;
   } pe_event_type;
endpackage

//--- src/pe_event_top.sv
// pe_event_top: per-thread performance event qualifiers with an AXI4-Lite control port.
// assumes pipeline status comes from logic on aclk, so it is read without synchronisers.
//
// Function
// - exactly one issue-width event every cycle
// - flag sync blocks and window-replacement blocks
// - static decode interlock covers sync and window
// - pulse when predicted-taken turns out non-branch
// - data wait: head memory access, data missing
// - stores excluded, atomics included in data wait
// - data miss latency counts only once older committed
// - noncache, int load, l2 miss sub-events
// - empty queue stall and storeport-full variant
// - execution wait outranks branch wait
// - flag head floating-point not completed
// - flag no-commit waits on register window
// - priority alternates while both threads run; count ready-but-no-priority cycles
// - commit-width events zero to three
// - flag write-port-limited commit cycles
// - qualified stall variants need commit priority
// - window wait and zero commit without priority
// - flag mixed single and double precision
// - separate instruction and data micro-TLB misses
// - cache misses; data latency tracks only head access
// - each prefetch gives exactly one outcome
// - thrashing events for instruction and data
`timescale 1ns/10ps
module pe_event_top
   import pe_pkg::*;
#(
   parameter int NUM_THREADS = 2
) (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic [PE_ADDR_W-1:0]          s_axi_awaddr,
   input  wire logic [2:0]                    s_axi_awprot,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [PE_ADDR_W-1:0]          s_axi_araddr,
   input  wire logic [2:0]                    s_axi_arprot,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  pe_thread_in_type [NUM_THREADS-1:0] thr_in,
   output pe_event_type [NUM_THREADS-1:0]     events
);

   // priority toggling is written for a two-thread core only
   if (NUM_THREADS != 2) begin : g_bad
      $error("pe_event_top: NUM_THREADS must be 2");
   end

   logic [PE_ADDR_W-1:0]              wr_addr;
   logic [31:0]                       wr_data;
   logic [3:0]                        wr_strb;
   logic                              mon_enable;
   logic                              prio_owner;
   logic                              both_active;
   pe_event_type [NUM_THREADS-1:0]    next_ev;

   // write channel: address and data taken in either order, answer after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= PE_RESP_OKAY;
         wr_addr       <= '0;
         wr_data       <= '0;
         wr_strb       <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            wr_addr       <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wr_data      <= s_axi_wdata;
            wr_strb      <= s_axi_wstrb;
         end
         if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_addr == PE_CTRL_OFFSET || wr_addr == PE_STATUS_OFFSET) ?
                            PE_RESP_OKAY : PE_RESP_DECERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // control register; status is read-only so writes to it are dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mon_enable <= PE_CTRL_ENABLE_RST;
      end else if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid &&
                   wr_addr == PE_CTRL_OFFSET && wr_strb[0]) begin
         mon_enable <= wr_data[PE_CTRL_ENABLE_BIT];
      end
   end

   // read channel: one cycle from address to data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= PE_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= PE_RESP_OKAY;
         unique case (s_axi_araddr)
            PE_CTRL_OFFSET: begin
               s_axi_rdata[PE_CTRL_ENABLE_BIT] <= mon_enable;
            end
            PE_STATUS_OFFSET: begin
               s_axi_rdata[PE_STATUS_OWNER_BIT] <= prio_owner;
               s_axi_rdata[PE_STATUS_ACTIVE_LSB +: NUM_THREADS] <=
                  {thr_in[1].active, thr_in[0].active};
            end
            default: begin
               s_axi_rresp <= PE_RESP_DECERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // commit priority: alternates while both threads run, else the lone active thread
   assign both_active = thr_in[0].active && thr_in[1].active;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prio_owner <= PE_PRIO_OWNER_RST;
      end else if (both_active) begin
         prio_owner <= ~prio_owner;
      end else begin
         prio_owner <= thr_in[1].active;
      end
   end

   // per-thread event decode
   for (genvar t = 0; t < NUM_THREADS; t++) begin : g_thr
      pe_thread_in_type s;
      logic             has_prio;
      logic             no_commit;
      logic             dwait;
      logic             iload;
      assign s         = thr_in[t];
      assign has_prio  = (prio_owner == 1'(t));
      assign no_commit = (s.commit_count == 3'h0);
      // head is the oldest entry, so its miss is visible only after older ones left
      assign dwait = no_commit && s.head_valid && s.head_mem && !s.head_data_ready &&
                     (!s.head_store || s.head_atomic);
      assign iload = no_commit && s.head_valid && s.head_int_load && !s.head_data_ready;

      always_comb begin
         next_ev[t] = '0;
         // widths above four are illegal and fold into four
         next_ev[t].issue_zero_event  = (s.issue_count == 3'h0);
         next_ev[t].issue_one_event   = (s.issue_count == 3'h1);
         next_ev[t].issue_two_event   = (s.issue_count == 3'h2);
         next_ev[t].issue_three_event = (s.issue_count == 3'h3);
         next_ev[t].issue_four_event  = (s.issue_count >= PE_MAX_WIDTH);
         next_ev[t].sync_issue_block    = s.sync_block;
         next_ev[t].window_issue_block  = s.window_block;
         next_ev[t].decode_static_intlk = s.sync_block || s.window_block ||
                                          s.static_block;
         next_ev[t].phantom_branch      = s.phantom_branch;
         // data wait family
         next_ev[t].data_wait_stall        = dwait;
         next_ev[t].noncache_data_stall    = dwait && s.head_noncache;
         next_ev[t].int_load_stall         = iload;
         next_ev[t].l2_miss_data_stall     = dwait && s.head_l2_miss;
         next_ev[t].l2_miss_int_load_stall = iload && s.head_l2_miss;
         // empty queue and completion waits
         next_ev[t].empty_queue_stall          = no_commit && !s.head_valid;
         next_ev[t].empty_queue_storeport_full = no_commit && !s.head_valid &&
                                                 s.storeport_full;
         next_ev[t].exec_completion_stall   = no_commit && s.head_valid &&
                                              s.head_exec_busy;
         next_ev[t].branch_completion_stall = no_commit && s.head_valid &&
                                              s.head_branch_busy && !s.head_exec_busy;
         next_ev[t].fp_completion_stall = no_commit && s.head_valid && s.head_fp &&
                                          s.head_exec_busy;
         next_ev[t].regwin_wait_stall   = no_commit && s.head_regwin_wait;
         next_ev[t].commit_prio_wait    = s.head_valid && s.head_ready &&
                                          !has_prio;
         // commit widths
         next_ev[t].commit_zero_event  = no_commit;
         next_ev[t].commit_one_event   = (s.commit_count == 3'h1);
         next_ev[t].commit_two_event   = (s.commit_count == 3'h2);
         next_ev[t].commit_three_event = (s.commit_count == 3'h3);
         next_ev[t].write_port_limit_event = s.gpr_port_limit &&
                                             (s.commit_count < PE_MAX_WIDTH);
         // variants qualified by holding commit priority
         next_ev[t].prio_data_wait_stall = has_prio && next_ev[t].data_wait_stall;
         next_ev[t].prio_noncache_data_stall = has_prio && next_ev[t].noncache_data_stall;
         next_ev[t].prio_int_load_stall = has_prio && next_ev[t].int_load_stall;
         next_ev[t].prio_l2_miss_data_stall = has_prio && next_ev[t].l2_miss_data_stall;
         next_ev[t].prio_l2_miss_int_load_stall = has_prio &&
                                                  next_ev[t].l2_miss_int_load_stall;
         next_ev[t].prio_empty_queue_stall = has_prio && next_ev[t].empty_queue_stall;
         next_ev[t].prio_empty_queue_storeport_full = has_prio &&
                                                      next_ev[t].empty_queue_storeport_full;
         next_ev[t].prio_exec_completion_stall = has_prio && next_ev[t].exec_completion_stall;
         next_ev[t].prio_branch_completion_stall = has_prio &&
                                                   next_ev[t].branch_completion_stall;
         next_ev[t].prio_fp_completion_stall = has_prio && next_ev[t].fp_completion_stall;
         // variants qualified by lacking commit priority, then unqualified precision, TLB and cache miss events
         next_ev[t].nonprio_regwin_wait = !has_prio && next_ev[t].regwin_wait_stall;
         next_ev[t].nonprio_commit_zero = !has_prio && no_commit;
         next_ev[t].fp_precision_mix     = s.fp_mixed;
         next_ev[t].instr_micro_tlb_miss = s.itlb_miss;
         next_ev[t].data_micro_tlb_miss  = s.dtlb_miss;
         next_ev[t].icache_miss_event    = s.icache_miss;
         next_ev[t].dcache_miss_event    = s.dcache_miss;
         // fetch and head access latencies are separate, so both can count in one cycle
         next_ev[t].icache_miss_latency  = s.fetch_miss_pending;
         next_ev[t].dcache_miss_latency  = s.head_valid && s.head_mem && s.head_dmiss_pending;
         // unknown outcome codes count as lost so the three stay exclusive
         next_ev[t].swpf_to_l2  = s.swpf_valid && s.swpf_result == PE_SWPF_TO_L2;
         next_ev[t].swpf_l1_hit = s.swpf_valid && s.swpf_result == PE_SWPF_HIT;
         next_ev[t].swpf_lost   = s.swpf_valid && s.swpf_result != PE_SWPF_TO_L2 &&
                                  s.swpf_result != PE_SWPF_HIT;
         next_ev[t].icache_thrash_event = s.ithrash;
         next_ev[t].dcache_thrash_event = s.dthrash;
      end
   end

   // event register: one pulse per cycle per condition, zero while disabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         events <= '0;
      end else begin
         events <= mon_enable ? next_ev : '0;
      end
   end

   // checks on thread zero, on priority toggling and on gating of both threads; event outputs lag their causes by one cycle
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_both_run;
      both_active ##1 both_active;
   endsequence

   property p_issue_onehot;
      $past(mon_enable) |-> $onehot({events[0].issue_zero_event, events[0].issue_one_event,
         events[0].issue_two_event, events[0].issue_three_event, events[0].issue_four_event});
   endproperty
   a_issue_onehot: assert property (p_issue_onehot) else $error("issue width not one-hot");

   property p_decode_cover;
      (events[0].sync_issue_block || events[0].window_issue_block) |->
         events[0].decode_static_intlk;
   endproperty
   a_decode_cover: assert property (p_decode_cover) else $error("static interlock missed");

   property p_store_excl;
      $past(mon_enable && thr_in[0].head_store && !thr_in[0].head_atomic) |->
         !events[0].data_wait_stall;
   endproperty
   a_store_excl: assert property (p_store_excl) else $error("store counted in data wait");

   property p_exec_over_branch;
      !(events[0].exec_completion_stall && events[0].branch_completion_stall);
   endproperty
   a_exec_over_branch: assert property (p_exec_over_branch) else $error("two completion waits");

   property p_prio_toggle;
      s_both_run |-> prio_owner != $past(prio_owner);
   endproperty
   a_prio_toggle: assert property (p_prio_toggle) else $error("priority did not alternate");

   property p_prio_variant;
      events[0].prio_data_wait_stall |->
         events[0].data_wait_stall && $past(prio_owner) == 1'b0;
   endproperty
   a_prio_variant: assert property (p_prio_variant) else $error("prio data wait without priority");

   property p_nonprio_zero;
      events[0].nonprio_commit_zero |->
         events[0].commit_zero_event && $past(prio_owner) == 1'b1;
   endproperty
   a_nonprio_zero: assert property (p_nonprio_zero) else $error("nonprio zero with priority");

   property p_swpf_one;
      $past(mon_enable && thr_in[0].swpf_valid) |->
         $onehot({events[0].swpf_to_l2, events[0].swpf_lost, events[0].swpf_l1_hit});
   endproperty
   a_swpf_one: assert property (p_swpf_one) else $error("prefetch outcome not unique");

   property p_gate;
      !$past(mon_enable) |-> events == '0;
   endproperty
   a_gate: assert property (p_gate) else $error("event while disabled");

endmodule

//--- tb/pe_pipe_model.sv
// pe_pipe_model: stand-in for the issue, commit and cache logic of both threads.
// assumes the bench sets the wanted status; it shows on thr_in one clock later.
`timescale 1ns/10ps
module pe_pipe_model
   import pe_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  pe_thread_in_type [1:0] want,
   output pe_thread_in_type [1:0] thr_in
);
   // registered like real pipeline status; quiet while in reset
   always_ff @(posedge aclk) begin
      if (!aresetn) thr_in <= '0;
      else thr_in <= want;
   end
endmodule

//--- tb/tb_top.sv
// tb_top: directed scenarios for the perf event block and its control port.
// assumes one 200 MHz clock; status reaches the block through the pipeline model.
`timescale 1ns/10ps
module tb_top
   import pe_pkg::*;
;
   logic                   aclk, aresetn;
   logic [7:0]             awaddr, araddr;
   logic                   awvalid, wvalid, bready, arvalid, rready;
   logic [31:0]            wdata, rdata, d;
   logic                   awready, wready, bvalid, arready, rvalid;
   logic [1:0]             bresp, rresp, r, q;
   pe_thread_in_type [1:0] want, thr_in;
   pe_event_type [1:0]     ev;
   pe_thread_in_type       s;
   int                     bad_count, checks;

   pe_pipe_model i_pipe (.aclk(aclk), .aresetn(aresetn), .want(want), .thr_in(thr_in));
   pe_event_top #(.NUM_THREADS(2)) i_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .thr_in(thr_in), .events(ev));

   // free-running core clock
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d, bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // write: each channel held until its own ready; no latency assumed
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
      @(posedge aclk);
      awaddr <= a;
      wdata <= dt;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      dt = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   // status lands in the model, then in the block, then on the events
   task automatic put(input pe_thread_in_type a, input pe_thread_in_type b);
      @(posedge aclk);
      want[0] <= a;
      want[1] <= b;
      repeat (2) @(posedge aclk);
      #1;
   endtask

   task automatic t_regs();
      s = '0;
      s.active = 1'b1;
      put(s, '0);
      chk("events while disabled", 32'h0, 32'(ev[0].issue_zero_event));
      axi_rd(PE_CTRL_OFFSET, d, r);
      chk("ctrl reset", {31'h0, PE_CTRL_ENABLE_RST}, d);
      axi_rd(8'h10, d, r);
      chk("unmapped read", {30'h0, PE_RESP_DECERR}, {d[29:0], r});
      axi_wr(8'h10, 32'h1, r);
      chk("unmapped write", {30'h0, PE_RESP_DECERR}, {30'h0, r});
      axi_wr(PE_STATUS_OFFSET, 32'hffff_ffff, r);
      chk("status write", {30'h0, PE_RESP_OKAY}, {30'h0, r});
      axi_rd(PE_STATUS_OFFSET, d, r);
      chk("status", 32'h2, d);
      axi_wr(PE_CTRL_OFFSET, 32'h1, r);
      axi_rd(PE_CTRL_OFFSET, d, r);
      chk("ctrl enable", 32'h1, d);
   endtask

   // one-hot width table, every count once
   task automatic t_issue();
      for (int k = 0; k < 8; k++) begin
         s.issue_count = 3'(k);
         put(s, '0);
         chk("issue width", 32'h1 << (k > 4 ? 4 : k), {27'h0, ev[0].issue_four_event,
             ev[0].issue_three_event, ev[0].issue_two_event, ev[0].issue_one_event,
             ev[0].issue_zero_event});
      end
   endtask

   // front-end stalls, commit widths and first-level misses
   task automatic t_front();
      s = '0;
      s.active = 1'b1;
      s.sync_block = 1'b1;
      s.phantom_branch = 1'b1;
      s.commit_count = 3'h1;
      s.icache_miss = 1'b1;
      s.fetch_miss_pending = 1'b1;
      put(s, '0);
      chk("front end", 32'hb, {28'h0, ev[0].sync_issue_block, ev[0].window_issue_block,
          ev[0].decode_static_intlk,
          ev[0].phantom_branch});
      chk("commit width", 32'h2, {28'h0, ev[0].commit_three_event, ev[0].commit_two_event,
          ev[0].commit_one_event, ev[0].commit_zero_event});
      s.sync_block = 1'b0;
      s.window_block = 1'b1;
      s.phantom_branch = 1'b0;
      s.commit_count = 3'h2;
      s.dcache_miss = 1'b1;
      s.head_valid = 1'b1;
      s.head_mem = 1'b1;
      s.head_dmiss_pending = 1'b1;
      put(s, '0);
      chk("front end", 32'h6, {28'h0, ev[0].sync_issue_block, ev[0].window_issue_block,
          ev[0].decode_static_intlk, ev[0].phantom_branch});
      chk("commit width", 32'h4, {28'h0, ev[0].commit_three_event, ev[0].commit_two_event,
          ev[0].commit_one_event, ev[0].commit_zero_event});
      chk("cache miss", 32'hf, {28'h0, ev[0].icache_miss_event, ev[0].icache_miss_latency,
          ev[0].dcache_miss_event, ev[0].dcache_miss_latency});
      s.window_block = 1'b0;
      s.static_block = 1'b1;
      put(s, '0);
      chk("front end", 32'h2, {28'h0, ev[0].sync_issue_block, ev[0].window_issue_block,
          ev[0].decode_static_intlk, ev[0].phantom_branch});
   endtask

   task automatic t_wait();
      s = '0;
      s.active = 1'b1;
      s.head_valid = 1'b1;
      s.head_mem = 1'b1;
      s.head_store = 1'b1;
      s.head_noncache = 1'b1;
      s.head_l2_miss = 1'b1;
      put(s, '0);
      chk("store data wait", 32'h0, 32'(ev[0].data_wait_stall));
      s.head_atomic = 1'b1;
      put(s, '0);
      chk("atomic data wait", 32'h3f, {26'h0, ev[0].data_wait_stall, ev[0].noncache_data_stall,
          ev[0].l2_miss_data_stall, ev[0].prio_data_wait_stall, ev[0].prio_noncache_data_stall,
          ev[0].prio_l2_miss_data_stall});
      s.head_store = 1'b0;
      s.head_atomic = 1'b0;
      s.head_int_load = 1'b1;
      put(s, '0);
      chk("int load wait", 32'hf, {28'h0, ev[0].int_load_stall,
          ev[0].l2_miss_int_load_stall, ev[0].prio_int_load_stall,
          ev[0].prio_l2_miss_int_load_stall});
      s = '0;
      s.active = 1'b1;
      s.head_valid = 1'b1;
      s.head_exec_busy = 1'b1;
      s.head_fp = 1'b1;
      s.head_branch_busy = 1'b1;
      put(s, '0);
      chk("exec over branch", 32'h2d, {26'h0, ev[0].exec_completion_stall,
          ev[0].branch_completion_stall, ev[0].fp_completion_stall,
          ev[0].prio_exec_completion_stall, ev[0].prio_branch_completion_stall,
          ev[0].prio_fp_completion_stall});
      s.head_exec_busy = 1'b0;
      s.head_regwin_wait = 1'b1;
      put(s, '0);
      chk("branch wait", 32'h6, {29'h0, ev[0].branch_completion_stall,
          ev[0].regwin_wait_stall,
          ev[0].nonprio_regwin_wait});
      s = '0;
      s.active = 1'b1;
      s.storeport_full = 1'b1;
      put(s, '0);
      chk("empty queue", 32'h3e, {26'h0, ev[0].empty_queue_stall, ev[0].empty_queue_storeport_full,
          ev[0].prio_empty_queue_stall, ev[0].prio_empty_queue_storeport_full,
          ev[0].commit_zero_event,
          ev[0].nonprio_commit_zero});
   endtask

   // both threads ready: right to commit must swap each cycle
   task automatic t_prio();
      s = '0;
      s.active = 1'b1;
      s.head_valid = 1'b1;
      s.head_ready = 1'b1;
      s.head_regwin_wait = 1'b1;
      put(s, s);
      q = {ev[1].commit_prio_wait, ev[0].commit_prio_wait};
      chk("one thread waits", 32'h1, 32'(q == 2'b01 || q == 2'b10));
      repeat (3) begin
         @(posedge aclk);
         #1;
         q = ~q;
         chk("priority swap", 32'(q), {30'h0, ev[1].commit_prio_wait,
             ev[0].commit_prio_wait});
         chk("nonprio zero", 32'(q), {30'h0, ev[1].nonprio_commit_zero,
             ev[0].nonprio_commit_zero});
         chk("nonprio window", 32'(q), {30'h0, ev[1].nonprio_regwin_wait,
             ev[0].nonprio_regwin_wait});
      end
   endtask

   task automatic t_misc();
      s = '0;
      s.active = 1'b1;
      s.swpf_valid = 1'b1;
      for (int c = 0; c < 4; c++) begin
         s.swpf_result = 2'(c);
         put(s, '0);
         chk("prefetch outcome", {29'h0, s.swpf_result == PE_SWPF_TO_L2,
             (s.swpf_result == PE_SWPF_LOST || c == 3), s.swpf_result == PE_SWPF_HIT},
             {29'h0, ev[0].swpf_to_l2, ev[0].swpf_lost, ev[0].swpf_l1_hit});
      end
      s = '0;
      s.active = 1'b1;
      s.itlb_miss = 1'b1;
      s.fp_mixed = 1'b1;
      s.gpr_port_limit = 1'b1;
      s.commit_count = 3'h3;
      s.dthrash = 1'b1;
      put(s, '0);
      chk("misc events", 32'h5e, {25'h0, ev[0].instr_micro_tlb_miss, ev[0].data_micro_tlb_miss,
          ev[0].fp_precision_mix, ev[0].write_port_limit_event, ev[0].commit_three_event,
          ev[0].dcache_thrash_event,
          ev[0].icache_thrash_event});
   endtask

   // reset, then the scenarios in turn
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      want = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_issue();
      t_front();
      t_wait();
      t_prio();
      t_misc();
      end_sim();
   end

   // hang guard, far beyond the hundred or so cycles the scenarios need
   initial begin
      repeat (5000) @(posedge aclk);
      bad_count++;
      end_sim();
   end
endmodule
